// ==== hdl/watchdog_timer.sv ====
// watchdog timer: fixed /256 stage, 3-bit prescaler, flags, reset outputs
// assumes: cpu side pulses commands through the plain register port
//
// Notes on behaviour
// - build option picks oscillator or instruction clock
// - disabled watchdog ignores clear commands and never times out; halt command still halts and sets its flag
// - fixed divide by 256 before prescaler
// - select bits 2..0 give ratio 2^n
// - upper select bits are plain flag storage
// - overflow while running: chip reset, expired flag
// - overflow while halted: warm reset of pc, sp
// - pin, clear command or halt clear counter
// - option enables exactly one clearing scheme
// - single clear clears immediately
// - pair scheme clears after both instructions
// - instruction clock stops counting while halted
// - dedicated oscillator keeps running while halted
// - expired flag: set on timeout, cleared clear/halt
// - halt flag: set by halt, cleared by clear
`timescale 1ns/1ns
`default_nettype none
module watchdog_timer
	import wdt_pkg::*;
#(
	parameter wdt_pkg::clk_src_t    CLK_SRC     = wdt_pkg::CLK_FROM_OSC,
	parameter wdt_pkg::clear_mode_t CLEAR_MODE  = wdt_pkg::CLEAR_SINGLE,
	parameter bit                   WDT_ENABLE  = 1'b1,
	parameter bit                   OSC_ENABLE  = 1'b1,
	parameter int                   OSC_DIV     = wdt_pkg::OSC_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire wdt_pkg::reg_req_t req,
	input  wire logic              ext_clear_in_pin_n,
	output var  logic [7:0]        rdata_ff,
	output var  logic              chip_reset_ff,
	output var  logic              warm_reset_ff,
	output var  logic              halted_ff
);
	import wdt_pkg::*;

	localparam int CNT_W = BASE_DIV_W + (1 << PRESCALE_W) - 1;
	localparam int OSC_W = $clog2(OSC_DIV + 1);

	logic [7:0]       watchdog_select_ff;
	logic             watchdog_expired_flag_ff;
	logic             halt_entered_flag_ff;
	logic             first_seen_ff;
	logic [1:0]       instr_div_ff;
	logic [OSC_W-1:0] osc_cnt_ff;
	logic [CNT_W-1:0] count_ff;
	logic             wr_cmd;
	logic             single_clear_instr;
	logic             first_clear_instr;
	logic             second_clear_instr;
	logic             halt_instr;
	logic             sw_clear;
	logic             wdt_clear;
	logic             osc_tick;
	logic             instr_tick;
	logic             wdt_tick;
	logic             overflow;
	logic [PRESCALE_W-1:0] sel;
	// status byte as software sees it; bits 7..6 and 3..0 stay zero here
	logic [7:0]       status_word;

	// command decode; disabled watchdog turns clear commands into no-ops, halt still decoded
	assign wr_cmd             = req.wr && req.addr == ADDR_CMD && WDT_ENABLE;
	assign single_clear_instr = wr_cmd && req.wdata[CMD_SINGLE_BIT];
	assign first_clear_instr  = wr_cmd && req.wdata[CMD_FIRST_BIT];
	assign second_clear_instr = wr_cmd && req.wdata[CMD_SECOND_BIT];
	assign halt_instr         = req.wr && req.addr == ADDR_CMD && req.wdata[CMD_HALT_BIT];

	// only the scheme chosen at build time can clear
	always_comb begin
		if (CLEAR_MODE == CLEAR_SINGLE) begin
			sw_clear = single_clear_instr;
		end else begin
			sw_clear = second_clear_instr && first_seen_ff;
		end
	end

	// first half of the pair is remembered until the second arrives
	always_ff @(posedge clk) begin
		if (srst || !ext_clear_in_pin_n) begin
			first_seen_ff <= 1'b0;
		end else if (sw_clear || halt_instr) begin
			first_seen_ff <= 1'b0;
		end else if (first_clear_instr && CLEAR_MODE == CLEAR_PAIR) begin
			first_seen_ff <= 1'b1;
		end
	end

	assign wdt_clear = !ext_clear_in_pin_n || sw_clear || (halt_instr && WDT_ENABLE) || overflow;

	// dedicated oscillator model: free-running tick, runs through halt
	always_ff @(posedge clk) begin
		if (srst || !OSC_ENABLE) begin
			osc_cnt_ff <= '0;
		end else if (osc_cnt_ff == OSC_W'(OSC_DIV - 1)) begin
			osc_cnt_ff <= '0;
		end else begin
			osc_cnt_ff <= osc_cnt_ff + 1'b1;
		end
	end
	assign osc_tick = OSC_ENABLE && osc_cnt_ff == OSC_W'(OSC_DIV - 1);

	// instruction clock is system clock / 4, frozen while halted
	always_ff @(posedge clk) begin
		if (srst) begin
			instr_div_ff <= '0;
		end else if (!halted_ff) begin
			instr_div_ff <= instr_div_ff + 1'b1;
		end
	end
	assign instr_tick = !halted_ff && instr_div_ff == INSTR_DIV_LAST;

	// source chosen at build time; noisy systems should use the oscillator
	// limitation: with the instruction clock a halted device is never woken by the watchdog
	assign wdt_tick = WDT_ENABLE && ((CLK_SRC == CLK_FROM_OSC) ? osc_tick : instr_tick);

	// one counter holds the /256 stage and the prescaler above it
	wdt_divider #(.WIDTH(CNT_W)) u_div (
		.clk      (clk),
		.clear    (srst || wdt_clear),
		.tick     (wdt_tick),
		.count_ff (count_ff)
	);

	// overflow when fixed stage plus selected prescaler bits are all ones
	assign sel = watchdog_select_ff[PRESCALE_LSB +: PRESCALE_W];
	always_comb begin
		overflow = wdt_tick && WDT_ENABLE;
		for (int i = 0; i < CNT_W; i++) begin
			if (i < BASE_DIV_W + int'(sel) && !count_ff[i]) begin
				overflow = 1'b0;
			end
		end
	end

	// select register: all bits stored; upper bits are only flags
	always_ff @(posedge clk) begin
		if (srst || chip_reset_ff) begin
			watchdog_select_ff <= SELECT_RESET;
		end else if (req.wr && req.addr == ADDR_SELECT) begin
			watchdog_select_ff <= req.wdata;
		end
	end

	// halt state: entered by halt command, left by overflow or pin
	always_ff @(posedge clk) begin
		if (srst || !ext_clear_in_pin_n) begin
			halted_ff <= 1'b0;
		end else if (overflow) begin
			halted_ff <= 1'b0;
		end else if (halt_instr) begin
			halted_ff <= 1'b1;
		end
	end

	// reset outputs are one-cycle pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			chip_reset_ff <= 1'b0;
			warm_reset_ff <= 1'b0;
		end else begin
			chip_reset_ff <= overflow && !halted_ff;
			warm_reset_ff <= overflow && halted_ff;
		end
	end

	// expired flag: timeout set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			watchdog_expired_flag_ff <= 1'b0;
		end else if (overflow) begin
			watchdog_expired_flag_ff <= 1'b1;
		end else if (sw_clear || (halt_instr && WDT_ENABLE)) begin
			watchdog_expired_flag_ff <= 1'b0;
		end
	end

	// halt flag
	always_ff @(posedge clk) begin
		if (srst) begin
			halt_entered_flag_ff <= 1'b0;
		end else if (halt_instr) begin
			halt_entered_flag_ff <= 1'b1;
		end else if (sw_clear) begin
			halt_entered_flag_ff <= 1'b0;
		end
	end

	// status byte built bit by bit so a one-bit flag is never shifted out of its own width
	always_comb begin
		status_word                   = 8'h00;
		status_word[EXPIRED_FLAG_BIT] = watchdog_expired_flag_ff;
		status_word[HALT_FLAG_BIT]    = halt_entered_flag_ff;
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (srst || !req.rd) begin
			rdata_ff <= '0;
		end else begin
			unique case (req.addr)
				ADDR_SELECT: rdata_ff <= watchdog_select_ff;
				ADDR_STATUS: rdata_ff <= status_word;
				default:     rdata_ff <= 8'h00;
			endcase
		end
	end

	// checks: all on clk, all quiet while srst is high

	// any clear source empties the whole chain next cycle
	a_clear_resets_cnt: assert property (@(posedge clk) disable iff (srst)
		wdt_clear |=> count_ff == '0) else $error("counter not cleared");

	// the pin alone must also drop halt and the pair memory
	a_pin_clears: assert property (@(posedge clk) disable iff (srst)
		!ext_clear_in_pin_n |=> count_ff == '0 && !halted_ff && !first_seen_ff) else $error("pin did not clear");

	// overflow while running becomes a chip reset and sets the flag
	a_overflow_chip: assert property (@(posedge clk) disable iff (srst)
		(overflow && !halted_ff) |=> chip_reset_ff && watchdog_expired_flag_ff) else $error("no chip reset");

	// chip reset is a pulse because the counter restarts on overflow
	a_chip_pulse: assert property (@(posedge clk) disable iff (srst)
		chip_reset_ff |=> !chip_reset_ff) else $error("chip reset too long");

	// overflow in halt is only a warm reset
	a_overflow_warm: assert property (@(posedge clk) disable iff (srst)
		(overflow && halted_ff) |=> warm_reset_ff && !chip_reset_ff) else $error("no warm reset");

	// a warm reset keeps the select register as it was
	a_warm_keeps_sel: assert property (@(posedge clk) disable iff (srst)
		(overflow && halted_ff && !(req.wr && req.addr == ADDR_SELECT))
		|=> watchdog_select_ff == $past(watchdog_select_ff)) else $error("warm reset lost select");

	// instruction clock source: no tick at all once halted
	a_halt_freeze: assert property (@(posedge clk) disable iff (srst)
		(CLK_SRC == CLK_FROM_INSTR && halted_ff && $past(halted_ff)) |-> !wdt_tick) else $error("tick in halt");

	// instruction ticks are at least four system clocks apart
	a_instr_rate: assert property (@(posedge clk) disable iff (srst)
		instr_tick |=> !instr_tick [*3]) else $error("instruction tick too fast");

	// the single instruction does nothing in the pair scheme
	a_pair_needs_first: assert property (@(posedge clk) disable iff (srst)
		(CLEAR_MODE == CLEAR_PAIR && single_clear_instr && !first_seen_ff && !second_clear_instr)
		|-> !sw_clear) else $error("wrong scheme cleared");

	// the single scheme clears in the very cycle of the command
	a_single_now: assert property (@(posedge clk) disable iff (srst)
		(CLEAR_MODE == CLEAR_SINGLE && single_clear_instr) |-> sw_clear) else $error("single clear ignored");

	// a disabled watchdog neither clears nor expires
	a_disabled_quiet: assert property (@(posedge clk) disable iff (srst)
		!WDT_ENABLE |-> !sw_clear && !overflow) else $error("disabled wdt acted");

	// halt always raises its flag
	a_halt_flag_set: assert property (@(posedge clk) disable iff (srst)
		halt_instr |=> halt_entered_flag_ff) else $error("halt flag not set");

	// clear without a same-cycle timeout drops the expired flag
	a_expired_clear: assert property (@(posedge clk) disable iff (srst)
		(sw_clear && !overflow) |=> !watchdog_expired_flag_ff) else $error("expired not cleared");

	// halt drops the expired flag as well
	a_halt_expired: assert property (@(posedge clk) disable iff (srst)
		(halt_instr && WDT_ENABLE && !overflow) |=> !watchdog_expired_flag_ff) else $error("halt kept expired");

	// select writes land whole, unless a chip reset reloads it
	a_select_write: assert property (@(posedge clk) disable iff (srst)
		(req.wr && req.addr == ADDR_SELECT && !chip_reset_ff) |=> watchdog_select_ff == $past(req.wdata))
		else $error("select not stored");

	// read data appear one cycle after the strobe
	a_read_lat: assert property (@(posedge clk) disable iff (srst)
		(req.rd && req.addr == ADDR_SELECT) |=> rdata_ff == $past(watchdog_select_ff)) else $error("bad read");

	// status read returns both flags in place
	a_status_read: assert property (@(posedge clk) disable iff (srst)
		(req.rd && req.addr == ADDR_STATUS) |=> rdata_ff == $past(status_word)) else $error("bad status read");

	// main scenarios
	c_chip_reset: cover property (@(posedge clk) disable iff (srst) chip_reset_ff);
	c_warm_reset: cover property (@(posedge clk) disable iff (srst) warm_reset_ff);
	c_sw_clear: cover property (@(posedge clk) disable iff (srst) sw_clear);
	c_pair_clear: cover property (@(posedge clk) disable iff (srst) CLEAR_MODE == CLEAR_PAIR && sw_clear);
	c_halt_wake: cover property (@(posedge clk) disable iff (srst) halted_ff ##1 !halted_ff);
endmodule // watchdog_timer
`default_nettype wire

// ==== hdl/wdt_divider.sv ====
// ripple-free binary divider chain counting watchdog ticks
// assumes: tick is a one-cycle pulse on clk
`timescale 1ns/1ns
`default_nettype none
module wdt_divider #(
	parameter int WIDTH = 15
) (
	input  wire logic             clk,
	input  wire logic             clear,
	input  wire logic             tick,
	output var  logic [WIDTH-1:0] count_ff
);
	// clear beats tick so a clear in the same cycle starts from zero
	always_ff @(posedge clk) begin
		if (clear) begin
			count_ff <= '0;
		end else if (tick) begin
			count_ff <= count_ff + 1'b1;
		end
	end
endmodule // wdt_divider
`default_nettype wire

// ==== inc/wdt_pkg.sv ====
// constants and carrier types for the watchdog block
// assumes: one 25 MHz clock, synchronous active-high reset
package wdt_pkg;
	// register map (plain port, byte index)
	localparam logic [1:0] ADDR_SELECT     = 2'h0;
	localparam logic [1:0] ADDR_STATUS     = 2'h1;
	localparam logic [1:0] ADDR_CMD        = 2'h2;
	localparam logic [7:0] SELECT_RESET    = 8'h07;
	// select register fields
	localparam int         PRESCALE_LSB    = 0;
	localparam int         PRESCALE_W      = 3;
	// status bit positions
	localparam int         HALT_FLAG_BIT   = 4;
	localparam int         EXPIRED_FLAG_BIT = 5;
	// command register bits
	localparam int         CMD_SINGLE_BIT  = 0;
	localparam int         CMD_FIRST_BIT   = 1;
	localparam int         CMD_SECOND_BIT  = 2;
	localparam int         CMD_HALT_BIT    = 3;
	// fixed divider and instruction-clock ratio
	localparam int         BASE_DIV_W      = 8;
	localparam int         INSTR_DIV       = 4;
	localparam logic [1:0] INSTR_DIV_LAST  = 2'(INSTR_DIV - 1);
	// nominal dedicated oscillator period and its cycle count at 25 MHz
	localparam int         OSC_PERIOD_NS   = 90000;
	localparam int         CLK_PERIOD_NS   = 40;
	localparam int         OSC_CYCLES      = OSC_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic {CLK_FROM_OSC, CLK_FROM_INSTR} clk_src_t;
	typedef enum logic {CLEAR_SINGLE, CLEAR_PAIR}     clear_mode_t;

	// register port carrier
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;
endpackage

// ==== sim/test_watchdog_timer_with_prescaler.sv ====
// testbench: four watchdogs (single clear, pair clear, instruction clock, disabled) share every input
// assumes: wdt_pkg compiled first; OSC_DIV shortened so the base timeout is 512 cycles
`timescale 1ns/1ns
`default_nettype none
module test_watchdog_timer_with_prescaler;
	import wdt_pkg::*;
	logic       clk;
	logic       srst;
	reg_req_t   req;
	logic       pin_n;
	logic [7:0] rd_a;
	logic       chip_a, chip_b, chip_c, warm_a, halt_a, warm_d, halt_d;
	int         errors, samples_checked, na, nb, nc, nwa, nwd;

	// one design per build option so one stimulus serves all
	watchdog_timer #(.OSC_DIV(2)) watchdog_timer_i (.clk(clk), .srst(srst), .req(req),
		.ext_clear_in_pin_n(pin_n), .rdata_ff(rd_a), .chip_reset_ff(chip_a), .warm_reset_ff(warm_a),
		.halted_ff(halt_a));
	watchdog_timer #(.OSC_DIV(2), .CLEAR_MODE(CLEAR_PAIR)) watchdog_timer_pair_i (.clk(clk),
		.srst(srst), .req(req), .ext_clear_in_pin_n(pin_n), .rdata_ff(), .chip_reset_ff(chip_b),
		.warm_reset_ff(), .halted_ff());
	// instruction clock source: a halt freezes it until the pin
	watchdog_timer #(.OSC_DIV(2), .CLK_SRC(CLK_FROM_INSTR)) watchdog_timer_instr_i (.clk(clk),
		.srst(srst), .req(req), .ext_clear_in_pin_n(pin_n), .rdata_ff(), .chip_reset_ff(),
		.warm_reset_ff(warm_d), .halted_ff(halt_d));
	watchdog_timer #(.OSC_DIV(2), .WDT_ENABLE(1'b0)) watchdog_timer_off_i (.clk(clk), .srst(srst),
		.req(req), .ext_clear_in_pin_n(pin_n), .rdata_ff(), .chip_reset_ff(chip_c),
		.warm_reset_ff(), .halted_ff());

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// pulses are one cycle wide, so count them per edge
	always @(posedge clk) begin
		if (!srst) begin
			na  <= na + int'(chip_a);
			nb  <= nb + int'(chip_b);
			nc  <= nc + int'(chip_c);
			nwa <= nwa + int'(warm_a);
			nwd <= nwd + int'(warm_d);
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic run(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one gap cycle after each strobe keeps drivers apart
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, output logic [7:0] got);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 got = rd_a;
		chk(got, exp);
	endtask

	task automatic pin_pulse;
		@(posedge clk);
		pin_n <= 1'b0;
		@(posedge clk);
		pin_n <= 1'b1;
	endtask

	task automatic t_regs;
		logic [7:0] g;
		rd_chk(ADDR_SELECT, 8'h07, g);
		rd_chk(ADDR_STATUS, 8'h00, g);
		rd_chk(2'h3, 8'h00, g);
		wr(ADDR_STATUS, 8'hff);
		rd_chk(ADDR_STATUS, 8'h00, g);
		wr(ADDR_SELECT, 8'hf8);
		rd_chk(ADDR_SELECT, 8'hf8, g);
		$display("test regs done");
	endtask

	task automatic t_timeout;
		logic [7:0] g;
		wr(ADDR_SELECT, 8'h00);
		pin_pulse();
		run(400);
		pin_pulse();
		run(500);
		chk(8'(na), 8'h00);
		run(30);
		chk(8'(na), 8'h01);
		chk(8'(nb), 8'h01);
		chk(8'(nc), 8'h00);
		rd_chk(ADDR_STATUS, 8'h20, g);
		$display("test timeout done");
	endtask

	task automatic t_single;
		logic [7:0] g;
		wr(ADDR_SELECT, 8'h00);
		pin_pulse();
		for (int i = 0; i < 4; i++) begin
			run(400);
			wr(ADDR_CMD, 8'h01);
		end
		chk(8'(na), 8'h01);
		chk(8'(nb), 8'h02);
		rd_chk(ADDR_STATUS, 8'h00, g);
		$display("test single done");
	endtask

	task automatic t_pair;
		wr(ADDR_SELECT, 8'h00);
		pin_pulse();
		for (int i = 0; i < 3; i++) begin
			run(350);
			wr(ADDR_CMD, 8'h02);
			run(20);
			wr(ADDR_CMD, 8'h04);
		end
		chk(8'(nb), 8'h02);
		chk(8'(na), 8'h02);
		$display("test pair done");
	endtask

	task automatic t_halt;
		logic [7:0] g;
		wr(ADDR_SELECT, 8'h01);
		wr(ADDR_CMD, 8'h08);
		#1 chk(8'(halt_a), 8'h01);
		rd_chk(ADDR_STATUS, 8'h10, g);
		run(990);
		chk(8'(nwa), 8'h00);
		run(50);
		chk(8'(nwa), 8'h01);
		chk(8'(na), 8'h02);
		chk(8'(halt_a), 8'h00);
		rd_chk(ADDR_SELECT, 8'h01, g);
		rd_chk(ADDR_STATUS, 8'h30, g);
		chk(8'(nwd), 8'h00);
		chk(8'(halt_d), 8'h01);
		pin_pulse();
		#1 chk(8'(halt_d), 8'h00);
		$display("test halt done");
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// tests take about 4750 cycles; allow 20000, about four times that
	initial begin
		#(40 * 20000);
		errors++;
		test_done();
	end

	initial begin
		errors = 0;
		samples_checked = 0;
		na = 0;
		nb = 0;
		nc = 0;
		nwa = 0;
		nwd = 0;
		srst = 1'b1;
		pin_n = 1'b1;
		req = '{addr: 2'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		run(8);
		srst <= 1'b0;
		t_regs();
		t_timeout();
		t_single();
		t_pair();
		t_halt();
		test_done();
	end
endmodule // test_watchdog_timer_with_prescaler
`default_nettype wire
